// ### src/basic_timer.sv
// basic 16-bit upcounting timer with register port
// assumes strobes and debug inputs come from logic on mclk
`timescale 1ns/100ps
module basic_timer
    import basic_timer_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // debug and slave controller
    input wire logic debug_halt,
    input wire logic debug_freeze_select,
    input wire logic slave_update,
    // event outputs
    output logic trigger_output,
    output logic update_irq,
    output logic update_dma_req
);

    // ============================================================
    // registers
    // ============================================================
    logic count_enable_bit_r;
    logic update_inhibit_r;
    logic update_source_select_r;
    logic single_shot_r;
    logic reload_buffer_enable_r;
    logic [2:0] trigger_output_select_r;
    logic update_irq_enable_r;
    logic update_dma_enable_r;
    logic update_pending_flag_r;
    logic [REG_W-1:0] count_value_r;
    logic [REG_W-1:0] divisor_value_r;
    logic [REG_W-1:0] reload_value_r;
    logic [REG_W-1:0] divisor_act_r;
    logic [REG_W-1:0] reload_shadow_r;
    logic internal_count_enable_r;
    logic [DATA_W-1:0] rdata_r;
    logic trig_r;
    logic dma_r;

    // ============================================================
    // register decode
    // ============================================================
    wire wr_ctrl = wr && (addr == OFF_CTRL_PRIMARY);
    wire wr_trig = wr && (addr == OFF_TRIG_CTRL);
    wire wr_reqen = wr && (addr == OFF_REQ_ENABLE);
    wire wr_status = wr && (addr == OFF_EVT_STATUS);
    wire wr_gen = wr && (addr == OFF_EVT_GENERATE);
    wire wr_count = wr && (addr == OFF_COUNT);
    wire wr_div = wr && (addr == OFF_DIVISOR);
    wire wr_reload = wr && (addr == OFF_RELOAD);

    function automatic logic [DATA_W-1:0] zext(input logic [REG_W-1:0] v);
        zext = {16'h0000, v};
    endfunction : zext

    // ============================================================
    // event generation
    // ============================================================
    logic update_request;
    logic sw_reinit;
    logic count_tick;
    logic overflow;
    logic update_event;
    logic qualifying;
    logic frozen;
    logic run;
    logic [REG_W-1:0] reload_act;
    logic [REG_W-1:0] count_nxt;

    assign update_request = wr_gen && wdata[BIT_UPD_REQ];
    assign sw_reinit = update_request || slave_update;
    assign frozen = debug_halt && debug_freeze_select;
    // unbuffered reload reaches the comparator at once
    assign reload_act = reload_buffer_enable_r ? reload_shadow_r
                                               : reload_value_r;
    assign run = internal_count_enable_r && !frozen
                 && (reload_act != RST_REG16);
    assign overflow = count_tick && (count_value_r >= reload_act);
    assign update_event = !update_inhibit_r
                          && (overflow || sw_reinit);
    assign qualifying = update_event
                        && (overflow || !update_source_select_r);

    divider_counter u_div (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .run(run),
        .clear(sw_reinit),
        .ratio(divisor_act_r),
        .count_tick(count_tick)
    );

    assign count_nxt = sw_reinit ? RST_REG16 :
                       wr_count ? wdata[REG_W-1:0] :
                       overflow ? RST_REG16 :
                       count_tick ? count_value_r + 16'h0001 :
                       count_value_r;

    // ============================================================
    // control registers
    // ============================================================
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_enable_bit_r <= 1'b0;
            update_inhibit_r <= 1'b0;
            update_source_select_r <= 1'b0;
            single_shot_r <= 1'b0;
            reload_buffer_enable_r <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                count_enable_bit_r <= wdata[BIT_COUNT_EN];
                update_inhibit_r <= wdata[BIT_UPD_INHIBIT];
                update_source_select_r <= wdata[BIT_UPD_SRC_SEL];
                single_shot_r <= wdata[BIT_SINGLE_SHOT];
                reload_buffer_enable_r <= wdata[BIT_RELOAD_BUF];
            end else if (update_event && single_shot_r) begin
                count_enable_bit_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trigger_output_select_r <= RST_TRIG_SEL;
            update_irq_enable_r <= 1'b0;
            update_dma_enable_r <= 1'b0;
        end else if (ce) begin
            if (wr_trig) begin
                trigger_output_select_r <=
                    wdata[TRIG_SEL_MSB:TRIG_SEL_LSB];
            end
            if (wr_reqen) begin
                update_irq_enable_r <= wdata[BIT_IRQ_EN];
                update_dma_enable_r <= wdata[BIT_DMA_EN];
            end
        end
    end

    // pending flag: a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            update_pending_flag_r <= 1'b0;
        end else if (ce) begin
            if (qualifying) begin
                update_pending_flag_r <= 1'b1;
            end else if (wr_status && !wdata[BIT_PENDING]) begin
                update_pending_flag_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // time base
    // ============================================================
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_value_r <= RST_REG16;
            internal_count_enable_r <= 1'b0;
        end else if (ce) begin
            count_value_r <= count_nxt;
            internal_count_enable_r <= count_enable_bit_r;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divisor_value_r <= RST_REG16;
            reload_value_r <= RST_REG16;
        end else if (ce) begin
            if (wr_div) begin
                divisor_value_r <= wdata[REG_W-1:0];
            end
            if (wr_reload) begin
                reload_value_r <= wdata[REG_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divisor_act_r <= RST_REG16;
            reload_shadow_r <= RST_REG16;
        end else if (ce) begin
            if (update_event) begin
                divisor_act_r <= divisor_value_r;
                reload_shadow_r <= reload_value_r;
            end else if (!reload_buffer_enable_r) begin
                reload_shadow_r <= reload_value_r;
            end
        end
    end

    // ============================================================
    // outputs
    // ============================================================
    logic trig_nxt;

    always_comb begin
        case (trig_sel_t'(trigger_output_select_r))
            TRIG_RESET: trig_nxt = update_request;
            TRIG_ENABLE: trig_nxt = internal_count_enable_r;
            TRIG_UPDATE: trig_nxt = update_event;
            default: trig_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trig_r <= 1'b0;
            dma_r <= 1'b0;
        end else if (ce) begin
            trig_r <= trig_nxt;
            dma_r <= qualifying && update_dma_enable_r;
        end else begin
            dma_r <= 1'b0;
        end
    end

    assign trigger_output = trig_r;
    assign update_dma_req = dma_r;
    assign update_irq = update_pending_flag_r && update_irq_enable_r;

    // ============================================================
    // read port
    // ============================================================
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        case (addr)
            OFF_CTRL_PRIMARY: rd_mux = zext({8'h00, reload_buffer_enable_r,
                3'h0, single_shot_r, update_source_select_r,
                update_inhibit_r, count_enable_bit_r});
            OFF_TRIG_CTRL: rd_mux = zext({9'h000,
                trigger_output_select_r, 4'h0});
            OFF_REQ_ENABLE: rd_mux = zext({7'h00, update_dma_enable_r,
                7'h00, update_irq_enable_r});
            OFF_EVT_STATUS: rd_mux = zext({15'h0000,
                update_pending_flag_r});
            OFF_COUNT: rd_mux = zext(count_value_r);
            OFF_DIVISOR: rd_mux = zext(divisor_value_r);
            OFF_RELOAD: rd_mux = zext(reload_value_r);
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (ce) begin
            rdata_r <= rd ? rd_mux : 32'h00000000;
        end
    end

    assign rdata = rdata_r;

    // ============================================================
    // checks
    // ============================================================
    property p_freeze;
        @(posedge mclk) disable iff (!rstn)
        ce && frozen && !sw_reinit && !wr_count
            |=> $stable(count_value_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counter moved while frozen");

    property p_single_shot;
        @(posedge mclk) disable iff (!rstn)
        ce && update_event && single_shot_r && !wr_ctrl
            |=> !count_enable_bit_r;
    endproperty
    a_single_shot: assert property (p_single_shot)
        else $error("single shot did not stop counting");

    property p_inhibit_keeps;
        @(posedge mclk) disable iff (!rstn)
        ce && update_inhibit_r |=> $stable(divisor_act_r);
    endproperty
    a_inhibit_keeps: assert property (p_inhibit_keeps)
        else $error("active divisor changed while inhibited");

    property p_reinit;
        @(posedge mclk) disable iff (!rstn)
        ce && sw_reinit |=> count_value_r == RST_REG16;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("counter not cleared by update request");

    property p_enable_delay;
        @(posedge mclk) disable iff (!rstn)
        ce && $rose(count_enable_bit_r) ##0 ce[*1]
            |-> internal_count_enable_r == 1'b0 ##1
                (!ce || internal_count_enable_r);
    endproperty
    a_enable_delay: assert property (p_enable_delay)
        else $error("internal enable not one cycle late");

    property p_flag_set;
        @(posedge mclk) disable iff (!rstn)
        ce && qualifying |=> update_pending_flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("pending flag not set on update");

    property p_src_select;
        @(posedge mclk) disable iff (!rstn)
        ce && update_source_select_r && !overflow
            && !update_pending_flag_r && !(wr_ctrl) |=>
            !update_pending_flag_r;
    endproperty
    a_src_select: assert property (p_src_select)
        else $error("flag set by non-overflow source");

    property p_zero_reload;
        @(posedge mclk) disable iff (!rstn)
        reload_act == RST_REG16 |-> !count_tick;
    endproperty
    a_zero_reload: assert property (p_zero_reload)
        else $error("counter ticked with zero reload");

    property p_wrap;
        @(posedge mclk) disable iff (!rstn)
        ce && overflow && !sw_reinit && !wr_count
            |=> count_value_r == RST_REG16;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");

    property p_dma;
        @(posedge mclk) disable iff (!rstn)
        update_dma_req |-> $past(qualifying) && $past(update_dma_enable_r);
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma request without qualifying update");

    c_overflow: cover property (@(posedge mclk) overflow);
    c_single_shot: cover property (@(posedge mclk)
        update_event && single_shot_r);
    c_inhibited_reinit: cover property (@(posedge mclk)
        sw_reinit && update_inhibit_r);
    c_frozen: cover property (@(posedge mclk)
        frozen && internal_count_enable_r);

endmodule : basic_timer

// ### src/basic_timer_pkg.sv
// ============================================================
// basic timer package
// ============================================================
// register offsets, field positions, reset values and codes
// assumes byte addresses on a six-bit register address port
package basic_timer_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ============================================================
    // register offsets
    // ============================================================
    localparam logic [5:0] OFF_CTRL_PRIMARY = 6'h00;
    localparam logic [5:0] OFF_TRIG_CTRL = 6'h04;
    localparam logic [5:0] OFF_REQ_ENABLE = 6'h0C;
    localparam logic [5:0] OFF_EVT_STATUS = 6'h10;
    localparam logic [5:0] OFF_EVT_GENERATE = 6'h14;
    localparam logic [5:0] OFF_COUNT = 6'h24;
    localparam logic [5:0] OFF_DIVISOR = 6'h28;
    localparam logic [5:0] OFF_RELOAD = 6'h2C;

    // ============================================================
    // field positions
    // ============================================================
    localparam int BIT_COUNT_EN = 0;
    localparam int BIT_UPD_INHIBIT = 1;
    localparam int BIT_UPD_SRC_SEL = 2;
    localparam int BIT_SINGLE_SHOT = 3;
    localparam int BIT_RELOAD_BUF = 7;
    localparam int TRIG_SEL_LSB = 4;
    localparam int TRIG_SEL_MSB = 6;
    localparam int BIT_IRQ_EN = 0;
    localparam int BIT_DMA_EN = 8;
    localparam int BIT_PENDING = 0;
    localparam int BIT_UPD_REQ = 0;

    // ============================================================
    // reset values
    // ============================================================
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [2:0] RST_TRIG_SEL = 3'h0;

    // ============================================================
    // trigger output codes
    // ============================================================
    typedef enum logic [2:0] {
        TRIG_RESET = 3'h0,
        TRIG_ENABLE = 3'h1,
        TRIG_UPDATE = 3'h2
    } trig_sel_t;

endpackage : basic_timer_pkg

// ### src/divider_counter.sv
// ============================================================
// prescaler counter
// ============================================================
// divides the functional clock by ratio plus one
// assumes run, clear and ratio come from logic on mclk
`timescale 1ns/100ps
module divider_counter
    import basic_timer_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [REG_W-1:0] ratio,
    // tick toward the main counter
    output logic count_tick
);

    logic [REG_W-1:0] div_r;
    logic [REG_W-1:0] div_nxt;
    wire at_end = (div_r >= ratio);

    assign count_tick = run && at_end && !clear;
    assign div_nxt = clear ? RST_REG16 :
                     (run ? (at_end ? RST_REG16 : div_r + 16'h0001)
                          : div_r);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_r <= RST_REG16;
        end else if (ce) begin
            div_r <= div_nxt;
        end
    end

    // ============================================================
    // checks
    // ============================================================
    property p_div_clear;
        @(posedge mclk) disable iff (!rstn)
        ce && clear |=> div_r == RST_REG16;
    endproperty
    a_div_clear: assert property (p_div_clear)
        else $error("divider not cleared by reinit");

endmodule : divider_counter

// ### tb/tb_basic_timer.sv
// self-checking bench for the basic timer
// assumes the package and design sources are compiled first
`timescale 1ns/100ps
module tb_basic_timer;
    import basic_timer_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = 6'h00;
    logic [DATA_W-1:0] wdata = 32'h00000000;
    logic debug_halt = 1'b0;
    logic debug_freeze_select = 1'b0;
    logic slave_update = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic trigger_output, update_irq, update_dma_req;
    int err_count = 0;
    int tests_run = 0;
    int pulses;
    int since = 0;
    int gap_q = 0;
    int dma_n = 0;

    always #12.5 mclk = ~mclk;

    basic_timer u_basic_timer (.mclk(mclk), .rstn(rstn), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .debug_halt(debug_halt), .debug_freeze_select(debug_freeze_select),
        .slave_update(slave_update), .trigger_output(trigger_output),
        .update_irq(update_irq), .update_dma_req(update_dma_req));
    trigger_slave u_trigger_slave (.mclk(mclk), .rstn(rstn),
        .trig(trigger_output), .pulses(pulses));

    // interval between dma pulses, in mclk cycles
    always @(posedge mclk) begin
        if (update_dma_req === 1'b1) begin
            gap_q <= since;
            since <= 1;
            dma_n <= dma_n + 1;
        end else begin
            since <= since + 1;
        end
    end

    // ============================================================
    // shared tasks
    // ============================================================
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= {16'h0000, d};
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata[15:0];
    endtask : rd_reg

    task automatic rchk(input logic [5:0] a, input logic [15:0] e,
                        input string what);
        logic [15:0] d;
        rd_reg(a, d);
        check(what, {16'h0000, d}, {16'h0000, e});
    endtask : rchk

    task automatic wait_dma(input int n);
        int target;
        int k;
        target = dma_n + n;
        for (k = 0; k < 3000 && dma_n < target; k++) begin
            @(posedge mclk);
            #1;
        end
        if (dma_n < target) begin
            err_count++;
            $display("MISMATCH dma pulse exp pulse seen none");
            report_and_stop();
        end
    endtask : wait_dma

    task automatic setup(input logic [15:0] rl, input logic [15:0] dv);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0000);
        wr_reg(OFF_DIVISOR, dv);
        wr_reg(OFF_RELOAD, rl);
        wr_reg(OFF_EVT_GENERATE, 16'h0001);
        wr_reg(OFF_EVT_STATUS, 16'h0000);
    endtask : setup

    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_reset;
        logic [5:0] offs [9] = '{OFF_CTRL_PRIMARY, OFF_TRIG_CTRL,
            OFF_REQ_ENABLE, OFF_EVT_STATUS, OFF_EVT_GENERATE, OFF_COUNT,
            OFF_DIVISOR, OFF_RELOAD, 6'h08};
        foreach (offs[i]) rchk(offs[i], 16'h0000, "reset value");
        check("irq at reset", {31'h0, update_irq}, 32'h0);
    endtask : t_reset

    task automatic t_fields;
        wr_reg(OFF_CTRL_PRIMARY, 16'hFFFE);
        rchk(OFF_CTRL_PRIMARY, 16'h008E, "control fields");
        wr_reg(OFF_TRIG_CTRL, 16'hFFFF);
        rchk(OFF_TRIG_CTRL, 16'h0070, "trigger fields");
        wr_reg(OFF_REQ_ENABLE, 16'hFFFF);
        rchk(OFF_REQ_ENABLE, 16'h0101, "enable fields");
        wr_reg(OFF_COUNT, 16'h1234);
        rchk(OFF_COUNT, 16'h1234, "count rw");
        wr_reg(OFF_DIVISOR, 16'hA5A5);
        rchk(OFF_DIVISOR, 16'hA5A5, "divisor rw");
        wr_reg(OFF_RELOAD, 16'h5A5A);
        rchk(OFF_RELOAD, 16'h5A5A, "reload rw");
        wr_reg(OFF_TRIG_CTRL, 16'h0000);
    endtask : t_fields

    task automatic t_period;
        logic [15:0] a;
        logic [15:0] b;
        setup(16'h0003, 16'h0000);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0001);
        wait_dma(2);
        check("period div 1", 32'(gap_q), 32'd4);
        wr_reg(OFF_DIVISOR, 16'h0002);
        wait_dma(3);
        check("period div 3", 32'(gap_q), 32'd12);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0000);
        rd_reg(OFF_COUNT, a);
        rd_reg(OFF_COUNT, b);
        check("stopped count", {16'h0, b}, {16'h0, a});
        rchk(OFF_EVT_STATUS, 16'h0001, "flag set");
        check("irq pending", {31'h0, update_irq}, 32'h1);
        wr_reg(OFF_EVT_STATUS, 16'h0000);
        rchk(OFF_EVT_STATUS, 16'h0000, "flag cleared");
        check("irq cleared", {31'h0, update_irq}, 32'h0);
    endtask : t_period

    task automatic t_sources;
        int n;
        int p;
        logic e;
        for (int i = 0; i < 8; i++) begin
            wr_reg(OFF_CTRL_PRIMARY, {13'h0000, i[1], i[0], 1'b0});
            wr_reg(OFF_EVT_STATUS, 16'h0000);
            wr_reg(OFF_COUNT, 16'h0005);
            n = dma_n;
            p = pulses;
            e = !i[0] && !i[1];
            if (i[2]) begin
                @(posedge mclk);
                slave_update <= 1'b1;
                @(posedge mclk);
                slave_update <= 1'b0;
            end else begin
                wr_reg(OFF_EVT_GENERATE, 16'h0001);
            end
            repeat (3) @(posedge mclk);
            #1;
            rchk(OFF_COUNT, 16'h0000, "count reinit");
            rchk(OFF_EVT_STATUS, {15'h0, e}, "flag source");
            check("dma source", 32'(dma_n - n), {31'h0, e});
            if (!i[2]) check("trig reset", 32'(pulses - p), 32'd1);
        end
        rchk(OFF_EVT_GENERATE, 16'h0000, "request self clear");
    endtask : t_sources

    task automatic t_trigger;
        int n;
        int p;
        setup(16'h0003, 16'h0000);
        wr_reg(OFF_TRIG_CTRL, 16'h0010);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0001);
        @(posedge mclk);
        #1;
        check("enable early", {31'h0, trigger_output}, 32'h0);
        @(posedge mclk);
        #1;
        check("enable trig", {31'h0, trigger_output}, 32'h1);
        wr_reg(OFF_TRIG_CTRL, 16'h0020);
        // let the last enable-level trigger reach the slave first
        @(posedge mclk);
        #1;
        n = dma_n;
        p = pulses;
        wait_dma(3);
        check("update trig", 32'(pulses - p), 32'(dma_n - n));
    endtask : t_trigger

    task automatic t_buffer;
        setup(16'h0009, 16'h0000);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0081);
        wait_dma(1);
        wr_reg(OFF_RELOAD, 16'h0004);
        wait_dma(1);
        check("buffered old", 32'(gap_q), 32'd10);
        wait_dma(1);
        check("buffered new", 32'(gap_q), 32'd5);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0001);
        wait_dma(1);
        wr_reg(OFF_RELOAD, 16'h0007);
        wait_dma(1);
        check("direct reload", 32'(gap_q), 32'd8);
    endtask : t_buffer

    task automatic t_misc;
        int n;
        logic [15:0] a;
        logic [15:0] b;
        setup(16'h0003, 16'h0000);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0009);
        wait_dma(1);
        repeat (2) @(posedge mclk);
        rchk(OFF_CTRL_PRIMARY, 16'h0008, "single shot");
        setup(16'h0000, 16'h0000);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0001);
        n = dma_n;
        repeat (20) @(posedge mclk);
        rchk(OFF_COUNT, 16'h0000, "zero reload hold");
        check("zero reload dma", 32'(dma_n - n), 32'd0);
        setup(16'hFFFF, 16'h0000);
        wr_reg(OFF_CTRL_PRIMARY, 16'h0001);
        debug_halt <= 1'b1;
        debug_freeze_select <= 1'b1;
        rd_reg(OFF_COUNT, a);
        rd_reg(OFF_COUNT, b);
        check("debug freeze", {16'h0, b}, {16'h0, a});
        @(posedge mclk);
        debug_freeze_select <= 1'b0;
        rd_reg(OFF_COUNT, a);
        rd_reg(OFF_COUNT, b);
        check("debug run", {16'h0, b - a}, 32'd2);
        @(posedge mclk);
        debug_halt <= 1'b0;
    endtask : t_misc

    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_fields();
        t_period();
        t_sources();
        t_trigger();
        t_buffer();
        t_misc();
        report_and_stop();
    end
endmodule : tb_basic_timer

// ### tb/trigger_slave.sv
// slave timer model: counts cycles with the trigger input high
// assumes the trigger is synchronous to mclk
`timescale 1ns/100ps
module trigger_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // trigger from the master timer
    input wire logic trig,
    // pulses seen
    output int pulses
);
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pulses <= 0;
        end else if (trig === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
endmodule : trigger_slave
